// ==== hdl/fbd_pkg.sv ====
// constants and types for the frame buffer dram interface, plus the clock divider
// assumes one system clock clk; every controller pin is synchronised before use
// Operation
// - draw input low marks drawing cycles; qualifies display and write enables
// - dual mode 1 display with read direction low is a window read
// - address latched on strobe; strobe pulses mean an access is running
// - hsync low with draw high under strobe gives row-only refresh
// - hsync low level means end of raster line
// - four active-low write enables from increment mode and address bits 1:0
// - eight frame address outputs multiplexed by increment mode
// - three leftover address bits latched and held for whole cycle
// - shift clock gate low halts shifter, paced by zoom attribute
// - base load in all modes, window load only window screens, dual mode 1
// - display cycle flag high in display cycles, low otherwise
// - draw and read direction decode the cycle type; strobe high is idle
// - divided clock is pixel clock over ratio from divide select
// - zoom and scroll attributes captured from the address bus
// - base load follows slower strobe rate during zoom; the load dot here counts pixel edges whatever the zoom
// - row address shown with row strobe, column address with column strobe
// - divide ratio is 4, 8 or 16
// - refresh asserts only row strobe
// - each scroll dot moves the scrollable load one dot earlier
`timescale 1ns/1ps
package fbd_pkg;
  localparam int ADDR_W = 19;
  localparam int FA_W   = 8;
  localparam int UP_W   = 3;
  // register port
  localparam int        REG_AW     = 2;
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam int        CTRL_MODE_LSB = 0;
  localparam int        CTRL_WSS_BIT  = 2;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  // attribute fields on the address bus during a display data phase
  localparam int HZ_LSB  = 8;
  localparam int HSD_LSB = 12;
  // address field positions
  localparam int ROW_HI_LSB = 8;
  localparam int COL_HI_LSB = 3;
  localparam int ROW_LO_LSB = 11;
  localparam int UPPER_LSB  = 16;
  // divider: base ratio shifted by select
  localparam logic [4:0] DIV_BASE    = 5'h04;
  localparam logic [1:0] DIV_SEL_MAX = 2'h2;
  localparam int         MAX_DOT_MHZ_DIV4 = 32;

  typedef enum logic [1:0] {FBD_SINGLE, FBD_DUAL0, FBD_DUAL1} fbd_access_e;
  typedef enum logic [2:0] {
    FBD_NONE, FBD_DRAW_WR, FBD_DRAW_RD, FBD_WINDOW, FBD_BACK, FBD_REFRESH
  } fbd_cycle_e;
endpackage

// divides synchronised pixel edges into the controller clock
module fbd_clock_divider
  import fbd_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // pixel edge and ratio select
  input  wire logic       pix_edge,
  input  wire logic [1:0] clock_divide_sel,
  // outputs
  output logic            divided_clock_out,
  output logic [4:0]      ratio_last
);
  logic [1:0] sel_eff;
  logic [4:0] ratio;
  logic [3:0] half_last;
  logic [3:0] cnt;

  // select 3 is not a legal ratio; it falls back to 16
  assign sel_eff   = (clock_divide_sel > DIV_SEL_MAX) ? DIV_SEL_MAX : clock_divide_sel;
  assign ratio     = DIV_BASE << sel_eff;
  assign half_last = 4'((ratio >> 1) - 5'h01);

  // toggle every half ratio of pixel edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt               <= 4'h0;
      divided_clock_out <= 1'b0;
      ratio_last        <= 5'h03;
    end else begin
      ratio_last <= ratio - 5'h01;
      if (pix_edge) begin
        if (cnt >= half_last) begin
          cnt               <= 4'h0;
          divided_clock_out <= ~divided_clock_out;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// ==== hdl/fbd_frame_buffer_dram_interface.sv ====
// frame buffer dram interface: cycle decode, address mux, dram strobes, shift loads
// assumes controller pins are asynchronous to clk and the pixel clock is below clk/2
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module fbd_frame_buffer_dram_interface
  import fbd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // controller pins
  input  wire logic              addr_strobe_n,
  input  wire logic              cycle_phase_in,
  input  wire logic              draw_n,
  input  wire logic              read_direction_in,
  input  wire logic              hsync_n,
  input  wire logic [ADDR_W-1:0] ctrl_address_bus,
  input  wire logic [1:0]        increment_mode_sel,
  input  wire logic [1:0]        clock_divide_sel,
  input  wire logic              pixel_clock_in,
  // register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic [7:0]             reg_rdata,
  // dram side
  output logic [FA_W-1:0]        frame_address_out,
  output logic [UP_W-1:0]        upper_address_out,
  output logic                   row_strobe_n,
  output logic                   col_strobe_n,
  output logic                   output_enable_n,
  output logic [3:0]             bank_write_enable_n,
  // video side
  output logic                   divided_clock_out,
  output logic                   shift_clock_gate,
  output logic                   base_shift_load_n,
  output logic                   window_shift_load_n,
  output logic                   display_cycle_flag
);
  localparam int PIN_W = ADDR_W + 10;

  typedef enum logic [1:0] {FBD_IDLE, FBD_ROW, FBD_COL} fbd_state_e;

  // synchroniser stages: stage one feeds stage two only
  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  pin_s1;
  logic [PIN_W-1:0]  pin_s2;
  logic              pix_prev;
  logic              as_prev;
  // synchronised views
  logic              as_s;
  logic              phase_s;
  logic              draw_s;
  logic              rd_s;
  logic              hsync_s;
  logic [ADDR_W-1:0] addr_s;
  logic [1:0]        im_s;
  logic [1:0]        cdm_s;
  logic              pix_s;
  // control and state
  logic [7:0]        ctrl;
  fbd_state_e        state;
  fbd_state_e        next_state;
  fbd_cycle_e        cyc_type;
  fbd_cycle_e        dec_type;
  fbd_cycle_e        cur_type;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] cur_addr;
  logic [3:0]        zoom_attr;
  logic [3:0]        scroll_dot_attr;
  logic [3:0]        zoom_cnt;
  logic [4:0]        dot_cnt;
  logic [4:0]        ratio_last;
  logic              phase_prev;
  // decode wires
  logic              as_fall;
  logic              pix_edge;
  logic              is_disp;
  logic              is_read;
  logic              cur_disp;
  logic              attr_take;
  fbd_access_e       acc_mode;
  logic              wss;
  logic [FA_W-1:0]   row_addr;
  logic [FA_W-1:0]   col_addr;
  logic [UP_W-1:0]   up_addr;
  logic [3:0]        we_pattern;
  logic [4:0]        scroll_tgt;
  logic [4:0]        base_tgt;
  logic [4:0]        win_tgt;
  logic              base_hit;
  logic              win_hit;
  logic              next_ras_n;
  logic              next_cas_n;
  logic              next_oe_n;
  logic [3:0]        next_we_n;
  logic [FA_W-1:0]   next_fa;
  logic              next_disp;
  logic [7:0]        next_rdata;

  assign pin_raw = {pixel_clock_in, clock_divide_sel, increment_mode_sel, ctrl_address_bus,
                    hsync_n, read_direction_in, draw_n, cycle_phase_in, addr_strobe_n};
  assign as_s    = pin_s2[0];
  assign phase_s = pin_s2[1];
  assign draw_s  = pin_s2[2];
  assign rd_s    = pin_s2[3];
  assign hsync_s = pin_s2[4];
  assign addr_s  = pin_s2[5 +: ADDR_W];
  assign im_s    = pin_s2[ADDR_W+5 +: 2];
  assign cdm_s   = pin_s2[ADDR_W+7 +: 2];
  assign pix_s   = pin_s2[ADDR_W+9];

  // two-stage synchroniser for every pin input
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // edge detectors look only at the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pix_prev   <= 1'b1; // matches synchroniser reset, no false edge
      as_prev    <= 1'b1;
      phase_prev <= 1'b1;
    end else begin
      pix_prev   <= pix_s;
      as_prev    <= as_s;
      phase_prev <= phase_s;
    end
  end

  assign as_fall  = as_prev & ~as_s;
  assign pix_edge = pix_s & ~pix_prev;
  assign acc_mode = fbd_access_e'(ctrl[CTRL_MODE_LSB +: 2]);
  assign wss      = ctrl[CTRL_WSS_BIT];

  // cycle decode from sync, draw and read direction
  always_comb begin
    if (!hsync_s && draw_s) begin
      dec_type = FBD_REFRESH;
    end else if (!draw_s) begin
      dec_type = rd_s ? FBD_DRAW_RD : FBD_DRAW_WR;
    end else begin
      dec_type = rd_s ? FBD_BACK : FBD_WINDOW;
    end
  end

  // the new cycle is visible in its first output cycle
  assign cur_type = as_fall ? dec_type : cyc_type;
  assign cur_addr = as_fall ? addr_s : addr_q;
  assign is_disp  = (cyc_type == FBD_WINDOW) || (cyc_type == FBD_BACK);
  assign cur_disp = (cur_type == FBD_WINDOW) || (cur_type == FBD_BACK);
  // window display is a read even with read direction low
  assign is_read  = (cur_type != FBD_DRAW_WR) && (cur_type != FBD_REFRESH);

  // address mux: mode 0 keeps high bits upper, others keep low bits for banking
  assign row_addr = (im_s == 2'h0) ? cur_addr[ROW_HI_LSB +: FA_W]
                                   : cur_addr[ROW_LO_LSB +: FA_W];
  assign col_addr = (im_s == 2'h0) ? cur_addr[0 +: FA_W]
                                   : cur_addr[COL_HI_LSB +: FA_W];
  assign up_addr  = (im_s == 2'h0) ? cur_addr[UPPER_LSB +: UP_W]
                                   : cur_addr[0 +: UP_W];

  // bank write enables: all, pair by bit 0, or one of four by bits 1:0
  always_comb begin
    case (im_s)
      2'h0:    we_pattern = 4'h0;
      2'h1:    we_pattern = cur_addr[0] ? 4'h3 : 4'hC;
      default: we_pattern = ~(4'h1 << cur_addr[1:0]);
    endcase
  end

  // access sequencer: row phase, then column phase on the data phase
  always_comb begin
    next_state = state;
    case (state)
      FBD_IDLE: if (as_fall) next_state = FBD_ROW;
      FBD_ROW: begin
        if (as_s) begin
          next_state = FBD_IDLE;
        end else if (phase_s && cyc_type != FBD_REFRESH) begin
          next_state = FBD_COL;
        end
      end
      FBD_COL: if (as_s) next_state = FBD_IDLE;
      default: next_state = FBD_IDLE;
    endcase
  end

  // strobe levels derived from the coming state so outputs stay registered
  assign next_ras_n = (next_state == FBD_IDLE);
  assign next_cas_n = (next_state != FBD_COL);
  assign next_oe_n  = !((next_state == FBD_COL) && is_read);
  assign next_we_n  = ((next_state == FBD_COL) && (cur_type == FBD_DRAW_WR) && !draw_s)
                      ? we_pattern : 4'hF;
  assign next_fa    = (next_state == FBD_COL) ? col_addr : row_addr;
  assign next_disp  = (next_state != FBD_IDLE) && cur_disp;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= FBD_IDLE;
      cyc_type <= FBD_NONE;
      addr_q   <= '0;
    end else begin
      state <= next_state;
      if (as_fall) begin
        cyc_type <= dec_type;
        addr_q   <= addr_s;
      end
    end
  end

  // dram output flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      row_strobe_n        <= 1'b1;
      col_strobe_n        <= 1'b1;
      output_enable_n     <= 1'b1;
      bank_write_enable_n <= 4'hF;
      frame_address_out   <= '0;
      upper_address_out   <= '0;
      display_cycle_flag  <= 1'b0;
    end else begin
      row_strobe_n        <= next_ras_n;
      col_strobe_n        <= next_cas_n;
      output_enable_n     <= next_oe_n;
      bank_write_enable_n <= next_we_n;
      frame_address_out   <= next_fa;
      display_cycle_flag  <= next_disp;
      if (as_fall) upper_address_out <= up_addr;
    end
  end

  // attributes ride the bus in a display data phase
  assign attr_take = is_disp && (state != FBD_IDLE) && phase_s && !phase_prev;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zoom_attr       <= 4'h0;
      scroll_dot_attr <= 4'h0;
    end else if (attr_take) begin
      zoom_attr       <= addr_s[HZ_LSB +: 4];
      scroll_dot_attr <= addr_s[HSD_LSB +: 4];
    end
  end

  // zoom pacing: shifter runs one dot in every zoom_attr+1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zoom_cnt         <= 4'h0;
      shift_clock_gate <= 1'b1;
    end else begin
      if (pix_edge) begin
        zoom_cnt <= (zoom_cnt >= zoom_attr) ? 4'h0 : zoom_cnt + 4'h1;
      end
      shift_clock_gate <= (zoom_cnt == 4'h0);
    end
  end

  // dot position within a display cycle restarts on every strobe and counts pixel edges up to 31, whatever the zoom
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dot_cnt <= 5'h00;
    end else if (as_fall) begin
      dot_cnt <= 5'h00;
    end else if (pix_edge && dot_cnt != 5'h1F) begin
      dot_cnt <= dot_cnt + 5'h01;
    end
  end

  // scroll moves the load earlier, one dot per step; clamps at the first dot
  assign scroll_tgt = ({1'b0, scroll_dot_attr} > ratio_last) ? 5'h00
                      : ratio_last - {1'b0, scroll_dot_attr};
  assign base_tgt   = (acc_mode == FBD_DUAL1 && wss) ? ratio_last : scroll_tgt;
  assign win_tgt    = (acc_mode == FBD_DUAL1 && !wss) ? ratio_last : scroll_tgt;
  assign base_hit   = is_disp && (state != FBD_IDLE) && pix_edge && dot_cnt == base_tgt;
  assign win_hit    = (cyc_type == FBD_WINDOW) && (acc_mode == FBD_DUAL1)
                      && (state != FBD_IDLE) && pix_edge && dot_cnt == win_tgt;

  // load pulses last one clk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_shift_load_n   <= 1'b1;
      window_shift_load_n <= 1'b1;
    end else begin
      base_shift_load_n   <= !base_hit;
      window_shift_load_n <= !win_hit;
    end
  end

  fbd_clock_divider u_div (
    .clk               (clk),
    .reset_n           (reset_n),
    .pix_edge          (pix_edge),
    .clock_divide_sel  (cdm_s),
    .divided_clock_out (divided_clock_out),
    .ratio_last        (ratio_last)
  );

  // register port: control steers load modes, status shows live cycle
  assign next_rdata = (reg_addr == REG_CTRL)   ? ctrl
                    : (reg_addr == REG_STATUS) ? {1'b0, state != FBD_IDLE, 1'b0,
                                                  hsync_s, 1'b0, cyc_type}
                    : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl      <= CTRL_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_write && reg_addr == REG_CTRL) ctrl <= reg_wdata;
      reg_rdata <= reg_read ? next_rdata : 8'h00;
    end
  end
endmodule

// ==== tb/fbd_ctrl_model.sv ====
// behavioural display controller: one frame buffer cycle per start pulse
// assumes start only while busy is low; kind codes follow fbd_cycle_e
`timescale 1ns/1ps
module fbd_ctrl_model (
  // bench side
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [2:0]  kind,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  attr,
  input  wire logic [5:0]  hold,
  output logic             busy,
  // controller pins
  output logic             addr_strobe_n,
  output logic             cycle_phase_in,
  output logic             draw_n,
  output logic             read_direction_in,
  output logic             hsync_n,
  output logic [18:0]      ctrl_address_bus
);
  logic [6:0]  cnt;
  logic [18:0] a_q;
  assign busy = (cnt != 7'h00);
  // pins idle at time zero
  initial begin
    {cnt, a_q, ctrl_address_bus} = '0;
    {addr_strobe_n, cycle_phase_in, draw_n, read_direction_in, hsync_n} = 5'h17;
  end
  // strobe low for hold cycles; a released bus shows the inverse, not a stale copy
  always @(posedge clk) begin
    if (start) begin
      cnt               <= 7'h01;
      a_q               <= addr;
      ctrl_address_bus  <= addr;
      addr_strobe_n     <= 1'b0;
      draw_n            <= (kind > 3'h2);
      read_direction_in <= (kind != 3'h1) && (kind != 3'h3);
      hsync_n           <= (kind != 3'h5);
    end else if (busy) begin
      cnt <= (cnt == hold + 7'h04) ? 7'h00 : cnt + 7'h01;
      if (cnt == 7'h03) begin
        cycle_phase_in   <= 1'b1;
        ctrl_address_bus <= {a_q[18:16], attr, a_q[7:0]};
      end
      if (cnt == {1'b0, hold}) begin
        addr_strobe_n    <= 1'b1;
        cycle_phase_in   <= 1'b0;
        ctrl_address_bus <= ~a_q;
      end
    end
  end
endmodule

// ==== tb/fbd_dram_assertions.sv ====
// checker for the dram side of the frame buffer interface
// assumes the controller holds cycle type while the strobe is low; the address is latched at the strobe fall
`timescale 1ns/1ps
module fbd_dram_checker
  import fbd_pkg::*;
(
  // clock, reset, controller pins
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              addr_strobe_n,
  input wire logic              draw_n,
  input wire logic              read_direction_in,
  input wire logic              hsync_n,
  input wire logic [ADDR_W-1:0] ctrl_address_bus,
  input wire logic [1:0]        increment_mode_sel,
  // dram and video side
  input wire logic [FA_W-1:0]   frame_address_out,
  input wire logic [UP_W-1:0]   upper_address_out,
  input wire logic              row_strobe_n,
  input wire logic              col_strobe_n,
  input wire logic              output_enable_n,
  input wire logic [3:0]        bank_write_enable_n,
  input wire logic              base_shift_load_n,
  input wire logic              display_cycle_flag
);
  logic              as_q;
  logic [ADDR_W-1:0] a_l;
  // expected mux outputs from the address seen at the strobe fall
  wire       m0    = (increment_mode_sel == 2'h0);
  wire       fall  = as_q && !addr_strobe_n;
  wire [7:0] e_row = m0 ? a_l[15:8] : a_l[18:11];
  wire [7:0] e_col = m0 ? a_l[7:0] : a_l[10:3];
  wire [2:0] e_up  = m0 ? a_l[18:16] : a_l[2:0];
  wire [3:0] e_we  = m0 ? 4'h0 : (increment_mode_sel == 2'h1) ? (a_l[0] ? 4'h3 : 4'hC)
                     : ~(4'h1 << a_l[1:0]);
  // the bus carries attributes in the data phase, so keep the address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      as_q <= 1'b1;
      a_l  <= '0;
    end else begin
      as_q <= addr_strobe_n;
      if (fall) a_l <= ctrl_address_bus;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    fall;
  endsequence
  sequence s_row;
    ##[2:4] $fell(row_strobe_n);
  endsequence
  property p_row;
    s_start |-> s_row ##0 (frame_address_out == e_row && upper_address_out == e_up);
  endproperty
  a_row: assert property (p_row) else $error("row phase address wrong");
  property p_refresh_row;
    s_start ##0 (!hsync_n && draw_n) |-> s_row;
  endproperty
  a_refresh_row: assert property (p_refresh_row) else $error("refresh row late");
  property p_refresh_quiet;
    s_start ##0 (!hsync_n && draw_n) |-> (col_strobe_n && output_enable_n) [*8];
  endproperty
  a_refresh_quiet: assert property (p_refresh_quiet) else $error("refresh drove col");
  property p_col;
    $fell(col_strobe_n) |-> frame_address_out == e_col && upper_address_out == e_up
      && !row_strobe_n && display_cycle_flag == draw_n;
  endproperty
  a_col: assert property (p_col) else $error("column phase wrong");
  property p_we;
    !(&bank_write_enable_n) |-> !draw_n && !read_direction_in && bank_write_enable_n == e_we;
  endproperty
  a_we: assert property (p_we) else $error("write enable wrong");
  property p_oe;
    !output_enable_n |-> !col_strobe_n && (draw_n || read_direction_in);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_idle;
    addr_strobe_n [*5] |-> row_strobe_n && col_strobe_n && output_enable_n
      && (&bank_write_enable_n);
  endproperty
  a_idle: assert property (p_idle) else $error("strobe active while idle");
  property p_load;
    $fell(base_shift_load_n) |=> base_shift_load_n;
  endproperty
  a_load: assert property (p_load) else $error("base load too long");
endmodule
bind fbd_frame_buffer_dram_interface fbd_dram_checker i_chk (
  .clk(clk), .reset_n(reset_n), .addr_strobe_n(addr_strobe_n), .draw_n(draw_n),
  .read_direction_in(read_direction_in), .hsync_n(hsync_n),
  .ctrl_address_bus(ctrl_address_bus), .increment_mode_sel(increment_mode_sel),
  .frame_address_out(frame_address_out), .upper_address_out(upper_address_out),
  .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
  .output_enable_n(output_enable_n), .bank_write_enable_n(bank_write_enable_n),
  .base_shift_load_n(base_shift_load_n), .display_cycle_flag(display_cycle_flag)
);

// ==== tb/testbench.sv ====
// self-checking bench for the frame buffer dram interface
// assumes fbd_ctrl_model on the controller pins and a 25 MHz clk
`timescale 1ns/1ps
module testbench;
  import fbd_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  im = 2'h0;
  logic [1:0]  cds = 2'h0;
  logic [1:0]  pc = 2'h0;
  logic [1:0]  ra = 2'h0;
  logic [7:0]  wd = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        go = 1'b0;
  logic [2:0]  kd = 3'h4;
  logic [18:0] ad = '0;
  logic [7:0]  at = 8'h00;
  logic        r_s, c_s, o_s, d_s, b_s, w_s, g_s, disp;
  logic [3:0]  we_s, ew;
  logic [15:0] t, bt, t0, n;
  wire         busy, as_n, ph, dr_n, rdir, hs_n, row_n, col_n, oe_n, dclk, bl_n, wl_n, dsp;
  wire         sg;
  wire [18:0]  mab;
  wire [7:0]   rdata, fa;
  wire [2:0]   up;
  wire [3:0]   we_n;
  int          n_fail = 0;
  int          samples_checked = 0;
  // clk at 25 MHz, pixel clock at a quarter of it
  always #20 clk = ~clk;
  always @(posedge clk) pc <= pc + 2'h1;
  fbd_ctrl_model i_ctrl (
    .clk(clk), .start(go), .kind(kd), .addr(ad), .attr(at), .hold(6'h28), .busy(busy),
    .addr_strobe_n(as_n), .cycle_phase_in(ph), .draw_n(dr_n), .read_direction_in(rdir),
    .hsync_n(hs_n), .ctrl_address_bus(mab)
  );
  fbd_frame_buffer_dram_interface i_dut (
    .clk(clk), .reset_n(reset_n), .addr_strobe_n(as_n), .cycle_phase_in(ph),
    .draw_n(dr_n), .read_direction_in(rdir), .hsync_n(hs_n), .ctrl_address_bus(mab),
    .increment_mode_sel(im), .clock_divide_sel(cds), .pixel_clock_in(pc[1]),
    .reg_addr(ra), .reg_wdata(wd), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
    .frame_address_out(fa), .upper_address_out(up), .row_strobe_n(row_n),
    .col_strobe_n(col_n), .output_enable_n(oe_n), .bank_write_enable_n(we_n),
    .divided_clock_out(dclk), .shift_clock_gate(sg), .base_shift_load_n(bl_n),
    .window_shift_load_n(wl_n), .display_cycle_flag(dsp)
  );
  // sticky seen-active flags (d_s seen high, the rest seen low), cleared as each cycle starts
  always @(posedge clk) begin
    t <= go ? 16'h0 : t + 16'h1;
    if (go) begin
      {r_s, c_s, o_s, d_s, b_s, w_s, g_s} <= 7'h0;
      we_s <= 4'hF;
    end else begin
      {r_s, c_s, o_s} <= {r_s, c_s, o_s} | ~{row_n, col_n, oe_n};
      {d_s, b_s, w_s, g_s} <= {d_s | dsp, b_s | !bl_n, w_s | !wl_n, g_s | !sg};
      we_s <= we_s & we_n;
      if (!bl_n && !b_s) bt <= t;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    {ra, wd, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] e);
    {ra, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    @(negedge clk);
    check(rdata, e);
    @(posedge clk);
  endtask
  // start aligned to the pixel clock so load timing repeats exactly
  task automatic cyc(input logic [2:0] k, input logic [18:0] a, input logic [7:0] x);
    int i;
    i = 0;
    while (pc != 2'h0) @(posedge clk);
    {kd, ad, at, go} <= {k, a, x, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1 && i < 200) begin
      @(posedge clk);
      i++;
    end
    if (i == 200) n_fail++;
  endtask
  task automatic wait_tog;
    logic d;
    d = dclk;
    n = 16'h0;
    while (dclk === d && n < 16'h200) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    reg_rd(REG_CTRL, CTRL_RESET);
    reg_wr(REG_STATUS, 8'hFF);
    reg_rd(REG_STATUS, 8'h10);
    reg_rd(2'h2, 8'h00);
    reg_wr(REG_CTRL, 8'h06);
    reg_rd(REG_CTRL, 8'h06);
    $display("test registers done");
    for (int cm = 0; cm < 3; cm++) begin
      reg_wr(REG_CTRL, 8'(cm));
      for (int md = 0; md < 4; md++) begin
        im <= md[1:0];
        for (int k = 1; k < 6; k++) begin
          cyc(k[2:0], {14'h2D6B, k[2:0], md[1:0]}, 8'h00);
          disp = (k == 3 || k == 4);
          ew = (k != 1) ? 4'hF : (md == 0) ? 4'h0 : (md == 1) ? 4'h3 : ~(4'h1 << md);
          check(r_s, 1);
          check(c_s, k != 5);
          check(o_s, k > 1 && k < 5);
          check(we_s, ew);
          check(d_s, disp);
          check(b_s, disp);
          check(w_s, cm == 2 && k == 3);
          check(g_s, 0);
          check(up, (md == 0) ? 3'h5 : {k[0], md[1:0]});
          reg_rd(REG_STATUS, 8'(k) | ((k == 5) ? 8'h00 : 8'h10));
        end
      end
    end
    $display("test cycles done");
    for (int s = 0; s < 3; s++) begin
      cds <= s[1:0];
      repeat (3) wait_tog();
      check(n, 16'h8 << s);
    end
    @(posedge clk);
    cds <= 2'h1;
    reg_wr(REG_CTRL, 8'h00);
    for (int s = 0; s < 4; s++) begin
      cyc(3'h4, 19'h12345, (s < 2) ? 8'h00 : 8'h20);
      if (s == 1) t0 = bt;
    end
    check(t0 - bt, 16'h8);
    // zoom of one halts the shifter on every other dot
    cyc(3'h4, 19'h12345, 8'h01);
    check(g_s, 1);
    $display("test divider and scroll done");
    test_done();
  end
  // hang guard: the tests need well under 10000 cycles
  initial begin
    #(40 * 30000);
    n_fail++;
    test_done();
  end
endmodule
